// ### design/pss_pkg.sv
// Shared widths, state codes and burst address helper for the pipelined SRAM block.
package pss_pkg;

	localparam int ADDR_W = 17;
	localparam int DATA_W = 36;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int BURST_W = 2;
	localparam int DEPTH = 131072;
	localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
	localparam logic [BURST_W-1:0] BURST_START = 2'h0;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 17'h00000;
	localparam logic [LANES-1:0] LANES_NONE = 4'h0;
	localparam logic [DATA_W-1:0] DATA_RESET = 36'h000000000;

	// One-hot cycle states; continue-deselect stays in the deselect state.
	typedef enum logic [4:0] {
		ST_DESEL = 5'h01,
		ST_READ = 5'h02,
		ST_WRITE = 5'h04,
		ST_BURST_RD = 5'h08,
		ST_BURST_WR = 5'h10
	} pss_state_t;

	// Low address bits of a burst step, interleaved or linear.
	function automatic logic [BURST_W-1:0] pss_burst_low(
		input logic [BURST_W-1:0] base,
		input logic [BURST_W-1:0] count,
		input logic interleave
	);
		if (interleave) begin
			return base ^ count;
		end
		return BURST_W'(base + count);
	endfunction : pss_burst_low

endpackage : pss_pkg

// ### design/pss_mem_if.sv
// Array access signals between the control logic and the storage core.
`timescale 1ns/1ns
interface pss_mem_if;
	import pss_pkg::*;

	logic rd_en;
	logic [ADDR_W-1:0] raddr;
	logic [DATA_W-1:0] rdata;
	logic wr_en;
	logic [ADDR_W-1:0] waddr;
	logic [LANES-1:0] lanes;
	logic [DATA_W-1:0] wdata;

	modport ctrl (output rd_en, raddr, wr_en, waddr, lanes, wdata, input rdata);
	modport array (input rd_en, raddr, wr_en, waddr, lanes, wdata, output rdata);
endinterface : pss_mem_if

// ### design/pss_burst_counter.sv
// Two-bit wrapping burst counter over the low address bits.
`timescale 1ns/1ns
module pss_burst_counter import pss_pkg::*; (
	input wire logic clock, // System clock.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic load, // New selected cycle loads the base address.
	input wire logic step, // Continuation cycle advances the count.
	input wire logic [ADDR_W-1:0] load_addr, // External address to load.
	input wire logic interleave, // High selects interleaved order.
	output logic [ADDR_W-1:0] next_addr // Address used by the next continuation.
);
	logic [ADDR_W-1:0] base;
	logic [BURST_W-1:0] count;
	logic [BURST_W-1:0] next_count;

	assign next_count = BURST_W'(count + BURST_STEP);
	assign next_addr = {base[ADDR_W-1:BURST_W], pss_burst_low(base[BURST_W-1:0], next_count,
		interleave)};

	// The count wraps by width, so every fourth step returns to the base.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			base <= ADDR_RESET;
			count <= BURST_START;
		end else if (load) begin
			base <= load_addr;
			count <= BURST_START;
		end else if (step) begin
			count <= next_count;
		end
	end
endmodule : pss_burst_counter

// ### design/pss_sram_array.sv
// Storage core with per-lane writes and a registered read port.
`timescale 1ns/1ns
module pss_sram_array import pss_pkg::*; (
	input wire logic clock, // System clock.
	input wire logic rst_n, // Synchronous reset, active low.
	pss_mem_if.array mem // Access port from the control logic.
);
	logic [DATA_W-1:0] store [0:DEPTH-1];

	always_ff @(posedge clock) begin
		if (mem.wr_en) begin
			for (int i = 0; i < LANES; i++) begin
				if (mem.lanes[i]) begin
					store[mem.waddr][i*LANE_W +: LANE_W] <= mem.wdata[i*LANE_W +: LANE_W];
				end
			end
		end
	end

	// The read register holds its word while no read is issued.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mem.rdata <= DATA_RESET;
		end else if (mem.rd_en) begin
			mem.rdata <= store[mem.raddr];
		end
	end
endmodule : pss_sram_array

// ### design/pss_sram_ctrl.sv
// Command decode, pipeline and data bus control of the pipelined synchronous SRAM.
// How it works
// - State, address and pipeline change only on a rising clock edge.
// - Continuation cycles share one code; the loading cycle fixes read or write.
// - Continue-deselect is only legal after a deselect cycle.
// - Dummy reads and write aborts are accepted but transfer no data.
// - A write with all lane strobes high stores nothing.
// - Data drivers are off during every write cycle, whatever output enable says.
// - A stall during a read keeps the data bus driven.
// - A stall during a write keeps the bus released and writes nothing.
// - No array write happens on an edge skipped by the clock gate.
// - With the clock gate high and sleep low the edge is ignored; everything holds except dq_oe, which still follows output enable.
// - Each lane strobe enables writing its own byte lane only.
// - Exactly the lanes with low strobes are written; any low means write.
// - The data bus is released from the first rising edge in reset until reset ends.
// - A two-bit counter wraps back to the loaded address every fourth step.
// - The counter advances on every continuation burst cycle.
// - Interleaved order exclusive-ORs the loaded low bits with the count.
// - Linear order adds one modulo four to the low bits each step.
`timescale 1ns/1ns
module pss_sram_ctrl import pss_pkg::*; (
	input wire logic clock, // Rising-edge clock, 250 MHz.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic [ADDR_W-1:0] address, // External address.
	input wire logic first_select_n, // Chip select, active low.
	input wire logic second_select_n, // Second chip select, active low.
	input wire logic third_select_hi, // Third chip select, active high.
	input wire logic advance_or_load_n, // Low loads a new cycle, high advances.
	input wire logic write_n, // Low writes, high reads.
	input wire logic lane_a_write_n, // Lane a write strobe, active low.
	input wire logic lane_b_write_n, // Lane b write strobe, active low.
	input wire logic lane_c_write_n, // Lane c write strobe, active low.
	input wire logic lane_d_write_n, // Lane d write strobe, active low.
	input wire logic clock_enable_n, // Clock gate; high skips the edge.
	input wire logic output_enable_n, // Output enable, active low.
	input wire logic sleep_request, // Sleep mode, active high.
	input wire logic burst_interleave, // High interleaved, low linear order.
	input wire logic [DATA_W-1:0] dq_in, // Data bus level seen at the pins.
	output wire logic [DATA_W-1:0] dq_out, // Read data towards the pins.
	output logic dq_oe // High while the block drives the data bus.
);
	pss_mem_if mem();

	pss_state_t state;
	pss_state_t next_state;
	logic go;
	logic load_cmd;
	logic step_cmd;
	logic selected;
	logic rd_state;
	logic wr_state;
	logic [LANES-1:0] lane_write;
	logic [ADDR_W-1:0] burst_addr;
	logic a_rd;
	logic a_wr;
	logic [ADDR_W-1:0] a_addr;
	logic [LANES-1:0] a_lanes;
	logic b_rd;
	logic b_wr;
	logic [ADDR_W-1:0] b_addr;
	logic [LANES-1:0] b_lanes;

	// Sleep and the clock gate both make the edge count for nothing.
	assign go = !sleep_request && !clock_enable_n;
	assign load_cmd = go && !advance_or_load_n;
	assign step_cmd = go && advance_or_load_n;
	assign selected = !first_select_n && !second_select_n && third_select_hi;
	assign rd_state = (state == ST_READ) || (state == ST_BURST_RD);
	assign wr_state = (state == ST_WRITE) || (state == ST_BURST_WR);
	assign lane_write = ~{lane_d_write_n, lane_c_write_n, lane_b_write_n, lane_a_write_n};

	always_comb begin
		next_state = state;
		if (sleep_request) begin
			next_state = ST_DESEL;
		end else if (load_cmd) begin
			if (!selected) begin
				next_state = ST_DESEL;
			end else if (write_n) begin
				next_state = ST_READ;
			end else begin
				next_state = ST_WRITE;
			end
		end else if (step_cmd) begin
			case (state)
				ST_READ, ST_BURST_RD: begin
					next_state = ST_BURST_RD;
				end
				ST_WRITE, ST_BURST_WR: begin
					next_state = ST_BURST_WR;
				end
				default: begin
					next_state = ST_DESEL;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= ST_DESEL;
		end else begin
			state <= next_state;
		end
	end

	pss_burst_counter u_counter (
		.clock(clock),
		.rst_n(rst_n),
		.load(load_cmd && selected),
		.step(step_cmd && (rd_state || wr_state)),
		.load_addr(address),
		.interleave(burst_interleave),
		.next_addr(burst_addr)
	);

	// Command stage: the cycle taken at this edge, with the address it uses.
	always_ff @(posedge clock) begin
		if (!rst_n || sleep_request) begin
			a_rd <= 1'b0;
			a_wr <= 1'b0;
			a_addr <= ADDR_RESET;
			a_lanes <= LANES_NONE;
		end else if (go) begin
			a_rd <= (load_cmd && selected && write_n) || (step_cmd && rd_state);
			a_wr <= (load_cmd && selected && !write_n) || (step_cmd && wr_state);
			a_addr <= load_cmd ? address : burst_addr;
			a_lanes <= lane_write;
		end
	end

	// Data stage: write data is taken here, read data has just been fetched.
	always_ff @(posedge clock) begin
		if (!rst_n || sleep_request) begin
			b_rd <= 1'b0;
			b_wr <= 1'b0;
			b_addr <= ADDR_RESET;
			b_lanes <= LANES_NONE;
		end else if (go) begin
			b_rd <= a_rd;
			b_wr <= a_wr;
			b_addr <= a_addr;
			b_lanes <= a_lanes;
		end
	end

	assign mem.rd_en = go && a_rd;
	assign mem.raddr = a_addr;
	assign mem.wr_en = go && b_wr && (b_lanes != LANES_NONE);
	assign mem.waddr = b_addr;
	assign mem.lanes = b_lanes;
	assign mem.wdata = dq_in;
	assign dq_out = mem.rdata;

	pss_sram_array u_array (
		.clock(clock),
		.rst_n(rst_n),
		.mem(mem)
	);

	// A stalled read keeps driving; writes and dummy reads never drive.
	always_ff @(posedge clock) begin
		if (!rst_n || sleep_request) begin
			dq_oe <= 1'b0;
		end else begin
			dq_oe <= (go ? a_rd : b_rd) && !output_enable_n;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_load_sel;
		load_cmd && selected;
	endsequence

	sequence s_step_go;
		step_cmd && (rd_state || wr_state);
	endsequence

	sequence s_load_rd;
		load_cmd && selected && write_n;
	endsequence

	sequence s_load_wr;
		load_cmd && selected && !write_n;
	endsequence

	a_edge_hold: assert property (
		clock_enable_n && !sleep_request |=> state == $past(state) && a_addr == $past(a_addr))
		else $error("state or address moved on a gated edge");

	a_gate_no_write: assert property (
		clock_enable_n && !sleep_request |-> !mem.wr_en ##1 (b_wr == $past(b_wr)))
		else $error("array written on a gated edge");

	a_abort_nowrite: assert property (
		mem.wr_en |-> b_wr && mem.lanes != LANES_NONE)
		else $error("write with no lane strobes reached the array");

	a_write_no_drive: assert property (
		dq_oe |-> b_rd && !b_wr && !$past(output_enable_n))
		else $error("bus driven outside a read with output enable");

	a_read_stall_drive: assert property (
		dq_oe && clock_enable_n && !sleep_request && !output_enable_n |=> dq_oe)
		else $error("stalled read released the bus");

	a_sleep_hiz: assert property (
		sleep_request |=> !dq_oe && !a_rd && !a_wr && state == ST_DESEL)
		else $error("sleep did not release the bus");

	a_reset_hiz: assert property (
		disable iff (1'b0) !rst_n |=> !dq_oe)
		else $error("bus driven during reset");

	a_burst_kind: assert property (
		s_step_go |=> (a_rd == $past(rd_state)) && (a_wr == $past(wr_state)))
		else $error("continuation changed the burst direction");

	a_deselect_idle: assert property (
		load_cmd && !selected |=> ((state == ST_DESEL)
		and (step_cmd |=> state == ST_DESEL && !a_rd && !a_wr)))
		else $error("deselect or continue-deselect issued an access");

	a_burst_wrap: assert property (
		s_load_sel ##1 s_step_go [*4] |=> a_addr == $past(address, 5))
		else $error("burst did not wrap to the loaded address");

	a_linear_step: assert property (
		(s_step_go and !burst_interleave and $past(go))
		|=> a_addr[1:0] == 2'($past(a_addr[1:0]) + BURST_STEP))
		else $error("linear burst step wrong");

	a_interleave: assert property (
		(s_load_sel and burst_interleave) ##1 (s_step_go and burst_interleave)
		|=> a_addr[1:0] == ($past(address[1:0], 2) ^ BURST_STEP))
		else $error("interleaved burst step wrong");

	// Write path: lanes are taken with the command and land two go edges later.
	a_lane_capture: assert property (
		s_load_wr |=> a_wr && a_lanes == ~$past({lane_d_write_n, lane_c_write_n,
			lane_b_write_n, lane_a_write_n}))
		else $error("lane strobes not captured with the write");

	a_write_land: assert property (
		(s_load_wr and lane_write != LANES_NONE) ##1 go ##1 go
		|-> mem.wr_en && mem.waddr == $past(address, 2))
		else $error("write did not land two go edges later");

	a_abort_land: assert property (
		(s_load_wr and lane_write == LANES_NONE) ##1 go ##1 go |-> !mem.wr_en)
		else $error("write abort reached the array");

	a_write_stage_off: assert property (
		wr_state && go |=> !dq_oe)
		else $error("bus driven behind a write");

	a_write_hold_stall: assert property (
		b_wr && clock_enable_n && !sleep_request |=> b_wr && !dq_oe)
		else $error("stalled write lost or bus driven");

	// Read path: fetched at the next go edge and driven only with output enable low.
	a_read_drive: assert property (
		s_load_rd ##1 (go && !output_enable_n) |=> dq_oe)
		else $error("read not driven after its fetch");

	a_dummy_read: assert property (
		go && a_rd && output_enable_n |=> !dq_oe)
		else $error("read driven with output enable high");

	a_desel_no_access: assert property (
		load_cmd && !selected |=> !a_rd && !a_wr)
		else $error("deselect cycle issued an access");

	// Stalls and sleep leave the array and the burst counter alone.
	a_stall_no_fetch: assert property (
		clock_enable_n |-> !mem.rd_en)
		else $error("array read on a gated edge");

	a_stall_count: assert property (
		clock_enable_n && !sleep_request ##1 $stable(burst_interleave)
		|-> burst_addr == $past(burst_addr))
		else $error("burst counter moved on a gated edge");

	a_sleep_no_access: assert property (
		sleep_request |-> !mem.wr_en && !mem.rd_en)
		else $error("array accessed while sleeping");

	a_reset_idle: assert property (
		disable iff (1'b0) !rst_n |=> state == ST_DESEL && !b_rd && !b_wr)
		else $error("pipeline not cleared by reset");

	a_step_desel: assert property (
		step_cmd && state == ST_DESEL |=> state == ST_DESEL && !a_rd && !a_wr)
		else $error("continue from deselect issued an access");

	// Burst addressing in linear order from the first step.
	a_linear_first: assert property (
		(s_load_sel and !burst_interleave) ##1 (s_step_go and !burst_interleave)
		|=> a_addr[1:0] == 2'($past(address[1:0], 2) + BURST_STEP))
		else $error("first linear burst step wrong");

endmodule : pss_sram_ctrl

// ### verification/pss_bus_model.sv
// Data bus as seen from the controller side of the pins.
`timescale 1ns/1ns
module pss_bus_model import pss_pkg::*; (
	input wire logic clock, // System clock.
	input wire logic dq_oe, // Block drives.
	input wire logic [DATA_W-1:0] dq_out, // Block data.
	input wire logic host_en, // Controller drives.
	input wire logic [DATA_W-1:0] host_data, // Controller data.
	output logic [DATA_W-1:0] dq_in // Bus level.
);
	logic [DATA_W-1:0] float_q = DATA_RESET;
	// A released bus flips every cycle so no stale value survives.
	always_ff @(posedge clock) begin
		float_q <= ~float_q;
	end
	assign dq_in = dq_oe ? dq_out : (host_en ? host_data : float_q);
endmodule : pss_bus_model

// ### verification/test_pipelined_sync_sram_control.sv
// Self-checking bench for the pipelined SRAM control block.
`timescale 1ns/1ns
module test_pipelined_sync_sram_control;
	import pss_pkg::*;
	typedef struct packed {
		logic [1:0] k;
		logic [ADDR_W-1:0] a;
		logic [LANES-1:0] ln;
		logic [DATA_W-1:0] d;
	} pss_ent_t;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] address = ADDR_RESET;
	logic s1_n = 1'b1, s2_n = 1'b1, s3 = 1'b0, adv_n = 1'b0, write_n = 1'b1;
	logic ce_n = 1'b0, oe_n = 1'b0, sleep = 1'b0, ilv = 1'b1, mode = 1'b1;
	logic [LANES-1:0] lanes_n = 4'hf;
	logic host_en = 1'b0;
	logic [DATA_W-1:0] host_data = DATA_RESET;
	wire logic [DATA_W-1:0] dq_in, dq_out;
	wire logic dq_oe;
	logic go_last = 1'b0, off_last = 1'b1;
	logic [DATA_W-1:0] mem [0:63];
	logic [DATA_W-1:0] exp_q [$];
	pss_ent_t sa = '0, sb = '0;
	logic [1:0] kind = 2'h0, cnt = 2'h0, dsel = 2'h0;
	logic [ADDR_W-1:0] base = ADDR_RESET;
	int num_errors = 0, check_count = 0, cycles = 0;
	pss_sram_ctrl uut (.clock(clock), .rst_n(rst_n), .address(address), .first_select_n(s1_n),
		.second_select_n(s2_n), .third_select_hi(s3), .advance_or_load_n(adv_n),
		.write_n(write_n), .lane_a_write_n(lanes_n[0]), .lane_b_write_n(lanes_n[1]),
		.lane_c_write_n(lanes_n[2]), .lane_d_write_n(lanes_n[3]), .clock_enable_n(ce_n),
		.output_enable_n(oe_n), .sleep_request(sleep), .burst_interleave(ilv),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
	pss_bus_model bus (.clock(clock), .dq_oe(dq_oe), .dq_out(dq_out), .host_en(host_en),
		.host_data(host_data), .dq_in(dq_in));
	initial forever #2 clock = ~clock;
	task automatic fail(input string msg);
		num_errors++;
		$display("mismatch at %0t: %s", $time, msg);
	endtask : fail
	task automatic end_sim();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim
	// One cycle; ctl is {sleep, clock gate, output enable}. The model follows the edge.
	task automatic cmd(input logic [1:0] op, input int a, input logic [3:0] ln,
		input logic [2:0] ctl);
		pss_ent_t e;
		logic ds;
		ds = (op == 2'h0 || op == 2'h3);
		@(negedge clock);
		address <= ADDR_W'(a);
		adv_n <= (op == 2'h3);
		write_n <= (op != 2'h2);
		lanes_n <= ln;
		{sleep, ce_n, oe_n} <= ctl;
		ilv <= mode;
		s1_n <= ds && dsel == 2'h0;
		s2_n <= ds && dsel == 2'h1;
		s3 <= !(ds && dsel == 2'h2);
		host_en <= (sb.k == 2'h2);
		host_data <= ctl[1] ? ~sb.d : sb.d;
		@(posedge clock);
		if (ctl[2]) begin
			sa = '0;
			sb = '0;
			kind = 2'h0;
		end else if (!ctl[1]) begin
			if (sa.k == 2'h1 && !ctl[0]) exp_q.push_back(mem[sa.a[5:0]]);
			for (int i = 0; i < LANES; i++) begin
				if (sb.k == 2'h2 && !sb.ln[i]) mem[sb.a[5:0]][i*LANE_W +: LANE_W] = sb.d[i*LANE_W +: LANE_W];
			end
			e = '0;
			if (op == 2'h3 && kind != 2'h0) begin
				cnt++;
				e.a = {base[ADDR_W-1:2], mode ? base[1:0] ^ cnt : base[1:0] + cnt};
				e.k = kind;
			end else if (!ds) begin
				base = ADDR_W'(a);
				cnt = 2'h0;
				kind = op;
				e.a = base;
				e.k = op;
			end else if (op == 2'h0) kind = 2'h0;
			e.ln = ln;
			e.d = DATA_W'({$urandom, $urandom});
			sb = sa;
			sa = e;
		end
	endtask : cmd
	always @(posedge clock) begin
		go_last <= rst_n && !sleep && !ce_n;
		off_last <= sleep || !rst_n;
		cycles++;
		if (cycles == 3000) begin
			fail("timeout");
			end_sim();
		end
	end
	always @(negedge clock) begin
		if (off_last) begin
			check_count++;
			if (dq_oe !== 1'b0) fail("bus driven in reset or sleep");
		end
		if (go_last && dq_oe === 1'b1) begin
			check_count++;
			if (exp_q.size() == 0) fail("bus driven with no read due");
			else if (dq_out !== exp_q.pop_front()) fail("read data");
		end
	end
	initial begin
		logic [1:0] op;
		int a;
		void'($urandom(32'h06d7));
		repeat (8) @(posedge clock);
		@(negedge clock);
		rst_n <= 1'b1;
		cmd(2'h3, 5, 4'h0, 3'h0);
		for (int i = 0; i < 64; i++) cmd(2'h2, i, 4'h0, 3'h0);
		for (int i = 0; i < 5; i++) cmd(2'h2, 3, ~(4'h1 << i), 3'h0);
		for (int i = 0; i < 3; i++) begin
			dsel = 2'(i);
			cmd(2'h0, 5, 4'h0, 3'h0);
			cmd(2'h3, 5, 4'h0, 3'h0);
		end
		for (int i = 0; i < 8; i++) cmd(2'h1, i, 4'hf, 3'h0);
		cmd(2'h1, 9, 4'hf, 3'h0);
		cmd(2'h0, 9, 4'hf, 3'h1);
		cmd(2'h1, 10, 4'hf, 3'h0);
		cmd(2'h0, 10, 4'hf, 3'h0);
		for (int i = 0; i < 3; i++) begin
			cmd(2'h2, 11, 4'h0, 3'h2);
			#1;
			check_count++;
			if (dq_oe !== 1'b1) fail("stalled read released the bus");
		end
		cmd(2'h2, 12, 4'h0, 3'h0);
		cmd(2'h0, 12, 4'h0, 3'h0);
		cmd(2'h2, 13, 4'h0, 3'h2);
		#1;
		check_count++;
		if (dq_oe !== 1'b0) fail("bus driven in stalled write");
		cmd(2'h1, 12, 4'h0, 3'h7);
		cmd(2'h1, 12, 4'hf, 3'h0);
		for (int m = 0; m < 8; m++) begin
			mode = m[2];
			cmd(2'h2, 16 + 5 * m, 4'h0, 3'h0);
			cmd(2'h3, 0, 4'h0, 3'h0);
			cmd(2'h3, 0, 4'hf, 3'h0);
			cmd(2'h3, 0, 4'h0, 3'h0);
			cmd(2'h3, 0, 4'h5, 3'h0);
			cmd(2'h0, 0, 4'h0, 3'h0);
			cmd(2'h1, 16 + 5 * m, 4'h0, 3'h0);
			for (int i = 0; i < 4; i++) cmd(2'h3, 0, 4'h0, 3'h0);
		end
		for (int i = 0; i < 300; i++) begin
			op = 2'($urandom % 3);
			a = $urandom % 64;
			if (op == 2'h1 && sa.k == 2'h2 && sa.a == ADDR_W'(a)) op = 2'h0;
			dsel = 2'($urandom % 3);
			cmd(op, a, 4'($urandom), {$urandom % 32 == 0, $urandom % 4 == 0, $urandom % 8 == 0});
		end
		repeat (3) cmd(2'h0, 0, 4'h0, 3'h0);
		check_count++;
		if (exp_q.size() != 0) fail("read data never driven");
		end_sim();
	end
endmodule : test_pipelined_sync_sram_control
